// ==== rtl/unb_baud.sv ====
// Sixteen-times sample tick generator for transmit and receive
`timescale 1ns/1ps
`default_nettype none
module unb_baud
  (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        fixedMode,
    input  wire logic        baudDoubler,
    input  wire logic        timer1Overflow,
    input  wire logic        txTimer2Select,
    input  wire logic        rxTimer2Select,
    input  wire logic [15:0] timer2Reload,
    unb_tick_if.source       ticks
  );
  import unb_pkg::*;

  typedef struct packed {
    logic [1:0]  preDiv;
    logic        t1Half;
    logic        t2Half;
    logic [15:0] t2Count;
  } unb_baud_s;

  unb_baud_s st;
  unb_baud_s next_st;
  logic      fixTick;
  logic      t1Tick;
  logic      t2Tick;

  // ***********************************************************************
  // Dividers
  // ***********************************************************************
  // Fixed rate: core/64 or core/32 per bit; timer 1 halves unless doubled
  always_comb
  begin
    next_st = st;
    fixTick = st.preDiv == (baudDoubler ? FIX_FAST_LAST : FIX_SLOW_LAST);
    next_st.preDiv = fixTick ? 2'h0 : st.preDiv + 2'h1;
    if (timer1Overflow)
      next_st.t1Half = !st.t1Half;
    t1Tick = timer1Overflow && (baudDoubler || st.t1Half);
    // Timer 2 counts at core/2, so each bit lasts 32 reload distances
    next_st.t2Half = !st.t2Half;
    t2Tick = st.t2Half && st.t2Count == 16'hFFFF;
    if (st.t2Half)
      next_st.t2Count = t2Tick ? timer2Reload : st.t2Count + 16'h1;
    // Parked at the reload value while unused, else the first bit is 65536 counts late
    if (fixedMode || !(txTimer2Select || rxTimer2Select))
      next_st.t2Count = timer2Reload;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  // Timer 2 only serves the timer-rate mode
  assign ticks.txSample = fixedMode ? fixTick : (txTimer2Select ? t2Tick : t1Tick);
  assign ticks.rxSample = fixedMode ? fixTick : (rxTimer2Select ? t2Tick : t1Tick);

  // ***********************************************************************
  // Checks
  // ***********************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence fastHold;
    fixedMode && baudDoubler;
  endsequence

  chk_fixed_fast_rate: assert property (
    (ticks.txSample && fixedMode && baudDoubler) ##1 fastHold
      |-> !ticks.txSample ##1 (ticks.txSample || !(fixedMode && baudDoubler)))
    else $error("fixed fast rate tick spacing wrong");
endmodule : unb_baud
`default_nettype wire

// ==== rtl/unb_pkg.sv ====
// Shared constants for the nine-bit serial port
package unb_pkg;

  // ***********************************************************************
  // Clock and sampling
  // ***********************************************************************
  localparam int unsigned CLOCK_HZ       = 20_000_000;
  localparam int unsigned OVERSAMPLE     = 16;
  localparam int unsigned FIXED_SLOW_DIV = 64;
  localparam int unsigned FIXED_FAST_DIV = 32;
  localparam int unsigned T2_PRESCALE    = 2;
  // Last divider count of a sample tick in the fixed-rate mode, one less than the core clocks per tick
  localparam logic [1:0]  FIX_SLOW_LAST  = 2'(FIXED_SLOW_DIV / OVERSAMPLE - 1);
  localparam logic [1:0]  FIX_FAST_LAST  = 2'(FIXED_FAST_DIV / OVERSAMPLE - 1);

  // ***********************************************************************
  // Frame layout
  // ***********************************************************************
  localparam int unsigned FRAME_BITS    = 11;
  localparam logic [3:0]  TX_SHIFT_BITS = 4'(FRAME_BITS - 1);
  localparam logic [3:0]  STOP_IDX      = 4'(FRAME_BITS - 1);
  localparam logic [3:0]  DIV_LAST      = 4'(OVERSAMPLE - 1);
  localparam logic [3:0]  VOTE_FIRST    = 4'h7;
  localparam logic [3:0]  VOTE_MID      = 4'h8;
  localparam logic [3:0]  VOTE_LAST     = 4'h9;

  // ***********************************************************************
  // Interrupt mask register
  // ***********************************************************************
  localparam logic [7:0]  SFR_IRQ_MASK   = 8'hA8;
  localparam logic [7:0]  IRQ_MASK_RESET = 8'h00;
  localparam int unsigned GIE_BIT        = 7;
  localparam int unsigned P1_EN_BIT      = 6;
  localparam int unsigned P0_EN_BIT      = 4;

  typedef enum logic {RX_IDLE, RX_BUSY} unb_rx_e;

endpackage : unb_pkg

// ==== rtl/unb_serial.sv ====
// Nine-bit asynchronous serial port core with interrupt mask register
`timescale 1ns/1ps
`default_nettype none
module unb_serial
  #(
    parameter bit EXT_INTR = 1'b0
  )
  (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  sfrAddr,
    input  wire logic        sfrWrite,
    input  wire logic [7:0]  sfrWdata,
    output logic [7:0]       sfrRdata,
    input  wire logic        bufWrite,
    input  wire logic [7:0]  bufWdata,
    output logic [7:0]       serialBuffer,
    input  wire logic        txNinthBit,
    input  wire logic        rxEnable,
    input  wire logic        multiprocModeBit,
    input  wire logic        baudDoubler,
    input  wire logic        timerRateMode,
    input  wire logic        timer1Overflow,
    input  wire logic        txTimer2Select,
    input  wire logic        rxTimer2Select,
    input  wire logic [15:0] timer2Reload,
    input  wire logic        txDoneSet,
    input  wire logic        txDoneClear,
    input  wire logic        rxDoneSet,
    input  wire logic        rxDoneClear,
    output logic             txDoneFlag,
    output logic             rxDoneFlag,
    output logic             rxNinthBit,
    input  wire logic        serialInPin,
    output logic             serialOutPin,
    output logic             port0IrqRequest,
    output logic             timer2OvfSuppress
  );
  import unb_pkg::*;

  // Port 1 enable is forced low when the extended option is absent
  localparam logic [7:0] IRQ_KEEP = EXT_INTR ? 8'hFF : ~(8'h01 << P1_EN_BIT);

  typedef struct packed {
    logic       txActive;
    logic       txPending;
    logic [3:0] txBits;
    logic [3:0] txDiv;
    logic [9:0] txShift;
    logic [7:0] txHold;
    logic       serialOut;
    logic       txDone;
    logic       rxDone;
    logic       rxNinth;
    logic [7:0] rxBuf;
    logic       rxSync1;
    logic       rxSync2;
    logic       rxPrev;
    unb_rx_e    rxState;
    logic [3:0] rxDiv;
    logic [3:0] rxIdx;
    logic [1:0] rxVote;
    logic [8:0] rxShift;
    logic [7:0] irqMask;
  } unb_serial_s;

  unb_serial_s st;
  unb_serial_s next_st;
  unb_tick_if  ticks ();
  logic        txRoll;
  logic        txDoneEvt;
  logic        rxFall;
  logic        bitVal;
  logic        rxTry;
  logic        rxAccept;

  // Two of three samples decide the bit
  function automatic logic vote3(input logic [2:0] s);
    vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : vote3

  // ***********************************************************************
  // Rate generator
  // ***********************************************************************
  unb_baud u_baud
    (
      .clock          (clock),
      .sys_rst        (sys_rst),
      .fixedMode      (!timerRateMode),
      .baudDoubler    (baudDoubler),
      .timer1Overflow (timer1Overflow),
      .txTimer2Select (txTimer2Select),
      .rxTimer2Select (rxTimer2Select),
      .timer2Reload   (timer2Reload),
      .ticks          (ticks.source)
    );

  // ***********************************************************************
  // Next-state logic
  // ***********************************************************************
  always_comb
  begin
    next_st   = st;
    txDoneEvt = 1'b0;
    bitVal    = 1'b0;
    rxTry     = 1'b0;
    // Register write; reserved enables are simply stored
    if (sfrWrite && sfrAddr == SFR_IRQ_MASK)
      next_st.irqMask = sfrWdata & IRQ_KEEP;

    // Transmit bit clock keeps running so a write waits for the next rollover
    txRoll = ticks.txSample && st.txDiv == DIV_LAST;
    if (ticks.txSample)
      next_st.txDiv = st.txDiv + 4'h1;
    if (txRoll)
    begin
      if (st.txActive)
      begin
        if (st.txBits != 4'h0)
        begin
          next_st.serialOut = st.txShift[0];
          next_st.txShift   = {1'b1, st.txShift[9:1]};
          next_st.txBits    = st.txBits - 4'h1;
          txDoneEvt         = st.txBits == 4'h1;
        end
        else
          next_st.txActive = 1'b0;
      end
      else if (st.txPending)
      begin
        next_st.txActive  = 1'b1;
        next_st.txPending = 1'b0;
        next_st.serialOut = 1'b0;
        next_st.txShift   = {1'b1, txNinthBit, st.txHold};
        next_st.txBits    = TX_SHIFT_BITS;
      end
    end
    // A write always queues a frame, even while one is on the line
    if (bufWrite)
    begin
      next_st.txHold    = bufWdata;
      next_st.txPending = 1'b1;
    end

    // Receive pin crosses in through two flops before any use
    next_st.rxSync1 = serialInPin;
    next_st.rxSync2 = st.rxSync1;
    next_st.rxPrev  = st.rxSync2;
    rxFall = st.rxPrev && !st.rxSync2;
    unique case (st.rxState)
      RX_IDLE:
      begin
        // Ticks run free, so the first sample of a bit may land up to one tick late
        if (rxEnable && rxFall)
        begin
          next_st.rxState = RX_BUSY;
          next_st.rxDiv   = 4'h0;
          next_st.rxIdx   = 4'h0;
        end
      end
      RX_BUSY:
      begin
        if (ticks.rxSample)
        begin
          next_st.rxDiv = st.rxDiv + 4'h1;
          if (st.rxDiv == VOTE_FIRST || st.rxDiv == VOTE_MID)
            next_st.rxVote = {st.rxVote[0], st.rxSync2};
          if (st.rxDiv == VOTE_LAST)
          begin
            bitVal        = vote3({st.rxVote, st.rxSync2});
            next_st.rxIdx = st.rxIdx + 4'h1;
            if (st.rxIdx == 4'h0)
            begin
              if (bitVal)
                next_st.rxState = RX_IDLE;
            end
            else if (st.rxIdx == STOP_IDX)
            begin
              next_st.rxState = RX_IDLE;
              rxTry           = 1'b1;
            end
            else
              next_st.rxShift = {bitVal, st.rxShift[8:1]};
          end
        end
      end
    endcase

    // Multiprocessor mode drops frames whose ninth bit is zero
    rxAccept = rxTry && !st.rxDone && (!multiprocModeBit || st.rxShift[8]);
    if (rxAccept)
    begin
      next_st.rxBuf   = st.rxShift[7:0];
      next_st.rxNinth = st.rxShift[8];
    end

    // Set wins over a clear in the same cycle
    next_st.txDone = (st.txDone && !txDoneClear) || txDoneSet || txDoneEvt;
    next_st.rxDone = (st.rxDone && !rxDoneClear) || rxDoneSet || rxAccept;
  end

  // ***********************************************************************
  // State register
  // ***********************************************************************
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st           <= '0;
      st.serialOut <= 1'b1;
      st.txShift   <= '1;
      st.rxSync1   <= 1'b1;
      st.rxSync2   <= 1'b1;
      st.rxPrev    <= 1'b1;
      st.irqMask   <= IRQ_MASK_RESET;
    end
    else
      st <= next_st;
  end

  // ***********************************************************************
  // Outputs
  // ***********************************************************************
  // Unmapped register addresses read as zero
  assign sfrRdata          = (sfrAddr == SFR_IRQ_MASK) ? st.irqMask : 8'h00;
  assign serialBuffer      = st.rxBuf;
  assign txDoneFlag        = st.txDone;
  assign rxDoneFlag        = st.rxDone;
  assign rxNinthBit        = st.rxNinth;
  assign serialOutPin      = st.serialOut;
  // Only port 0 has flags here; port 1 enable is stored for software only when EXT_INTR is set
  assign port0IrqRequest   = st.irqMask[GIE_BIT] && st.irqMask[P0_EN_BIT]
                             && (st.txDone || st.rxDone);
  assign timer2OvfSuppress = txTimer2Select || rxTimer2Select;

  // ***********************************************************************
  // Checks
  // ***********************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence txStarting;
    txRoll && !st.txActive && st.txPending;
  endsequence

  sequence stopPlaced;
    txRoll && st.txActive && st.txBits == 4'h1;
  endsequence

  chk_tx_start_low: assert property (txStarting |=> !serialOutPin && st.txActive)
    else $error("frame start did not drive a low start bit");
  chk_tx_stop_done: assert property (stopPlaced |=> serialOutPin && txDoneFlag)
    else $error("stop bit without transmit-done flag");
  chk_tx_line_idle: assert property (!st.txActive |-> serialOutPin)
    else $error("line not high between frames");
  chk_rx_disabled: assert property (st.rxState == RX_IDLE && !rxEnable |=> st.rxState == RX_IDLE)
    else $error("reception began while disabled");
  chk_rx_reject_keep: assert property (rxTry && !rxAccept |=> $stable(serialBuffer) && $stable(rxNinthBit))
    else $error("rejected frame altered buffer");
  chk_rx_accept_set: assert property (rxAccept |=> rxDoneFlag && rxNinthBit == $past(st.rxShift[8]))
    else $error("accepted frame not flagged");
  chk_rx_mp_filter: assert property (rxTry && multiprocModeBit && !st.rxShift[8] |-> !rxAccept)
    else $error("data byte accepted in multiprocessor mode");
  chk_rx_start_abort: assert property (st.rxState == RX_BUSY && st.rxIdx == 4'h0 && bitVal
                                       |=> st.rxState == RX_IDLE)
    else $error("false start bit not abandoned");
  chk_irq_gate: assert property (port0IrqRequest |-> st.irqMask[GIE_BIT] && st.irqMask[P0_EN_BIT])
    else $error("interrupt raised while masked");
  chk_flag_sticky: assert property (rxDoneFlag && !rxDoneClear |=> rxDoneFlag)
    else $error("receive-done flag dropped without clear");
  // Receive start alignment and transmit ninth-bit capture
  chk_rx_div_align: assert property (st.rxState == RX_IDLE && rxEnable && rxFall |=> st.rxState == RX_BUSY && st.rxDiv == 4'h0)
    else $error("receive divider not reset at start edge");
  chk_tx_ninth_load: assert property (txStarting |=> st.txShift[8] == $past(txNinthBit))
    else $error("transmitted ninth bit not taken from control");
endmodule : unb_serial
`default_nettype wire

// ==== rtl/unb_tick_if.sv ====
// Sample-tick carrier between the rate generator and the serial core
`timescale 1ns/1ps
`default_nettype none
interface unb_tick_if;
  logic txSample;
  logic rxSample;
  modport source (output txSample, output rxSample);
  modport sink   (input txSample, input rxSample);
endinterface : unb_tick_if
`default_nettype wire

// ==== tb/unb_node.sv ====
// Remote serial node model: sends frames and captures transmitted ones
`timescale 1ns/1ps
`default_nettype none
module unb_node
  (
    input  wire logic       clock,
    input  wire logic [7:0] bitClks,
    input  wire logic       serialOutPin,
    output var  logic       serialInPin
  );
  logic [10:0] capQ[$];

  // Sample at mid bit so an edge slip of a clock or two does no harm
  initial
  begin
    logic [10:0] f;
    serialInPin = 1'b1;
    forever
    begin
      @(negedge serialOutPin);
      repeat (bitClks / 2) @(posedge clock);
      for (int i = 0; i < 11; i++)
      begin
        f[i] = serialOutPin;
        if (i < 10)
          repeat (bitClks) @(posedge clock);
      end
      capQ.push_back(f);
    end
  end

  // Whole frame; the line rests high afterwards like a pulled-up idle wire
  task automatic sendFrame(input logic [7:0] d, input logic nb);
    logic [10:0] f;
    f = {1'b1, nb, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      serialInPin <= f[i];
      repeat (bitClks) @(posedge clock);
    end
  endtask : sendFrame

  // Short low pulse that must not pass the start vote
  task automatic glitch(input int n);
    serialInPin <= 1'b0;
    repeat (n) @(posedge clock);
    serialInPin <= 1'b1;
    repeat (bitClks * 2) @(posedge clock);
  endtask : glitch
endmodule : unb_node
`default_nettype wire

// ==== tb/unb_serial_bench.sv ====
// Self-checking bench for the nine-bit serial port
`timescale 1ns/1ps
`default_nettype none
module unb_serial_bench;
  import unb_pkg::*;
  logic        clock, sys_rst, sfrWrite, bufWrite, txNinthBit, rxEnable, multiprocModeBit;
  logic        baudDoubler, timerRateMode, txTimer2Select, rxTimer2Select, serialInPin;
  logic        txDoneSet, txDoneClear, rxDoneSet, rxDoneClear, timer2OvfSuppress;
  logic        txDoneFlag, rxDoneFlag, rxNinthBit, serialOutPin, port0IrqRequest;
  logic [7:0]  sfrAddr, sfrWdata, sfrRdata, bufWdata, serialBuffer, bitClks, mBuf, d;
  logic [15:0] timer2Reload;
  logic        mNinth, mDone;
  logic        timer1Overflow;
  int          err_total, cmp_count, seed;

  // Device under test; timer 1 overflow comes from the rate setup
  unb_serial u_dut
    (
      .clock             (clock),
      .sys_rst           (sys_rst),
      .sfrAddr           (sfrAddr),
      .sfrWrite          (sfrWrite),
      .sfrWdata          (sfrWdata),
      .sfrRdata          (sfrRdata),
      .bufWrite          (bufWrite),
      .bufWdata          (bufWdata),
      .serialBuffer      (serialBuffer),
      .txNinthBit        (txNinthBit),
      .rxEnable          (rxEnable),
      .multiprocModeBit  (multiprocModeBit),
      .baudDoubler       (baudDoubler),
      .timerRateMode     (timerRateMode),
      .timer1Overflow    (timer1Overflow),
      .txTimer2Select    (txTimer2Select),
      .rxTimer2Select    (rxTimer2Select),
      .timer2Reload      (timer2Reload),
      .txDoneSet         (txDoneSet),
      .txDoneClear       (txDoneClear),
      .rxDoneSet         (rxDoneSet),
      .rxDoneClear       (rxDoneClear),
      .txDoneFlag        (txDoneFlag),
      .rxDoneFlag        (rxDoneFlag),
      .rxNinthBit        (rxNinthBit),
      .serialInPin       (serialInPin),
      .serialOutPin      (serialOutPin),
      .port0IrqRequest   (port0IrqRequest),
      .timer2OvfSuppress (timer2OvfSuppress)
    );
  unb_node u_node (.clock(clock), .bitClks(bitClks), .serialOutPin(serialOutPin),
                   .serialInPin(serialInPin));

  // 20 MHz core clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
    // One idle cycle so a following pulse never re-raises in the same step
    @(negedge clock);
  endtask : pulse

  task automatic sfrWr(input logic [7:0] a, input logic [7:0] v);
    sfrAddr = a;
    sfrWdata = v;
    pulse(sfrWrite);
  endtask : sfrWr

  // Rate choice: fixed /32 and /64, timer 2 at one and two reload steps,
  // timer 1 overflowing every clock with and without the doubler
  task automatic setMode(input logic [2:0] m);
    timerRateMode = m[1] | m[2];
    txTimer2Select = m[1];
    rxTimer2Select = m[1];
    timer1Overflow = m[2];
    baudDoubler = ~m[0];
    timer2Reload = m[0] ? 16'hFFFE : 16'hFFFF;
    bitClks = m[2] ? (m[0] ? 8'h20 : 8'h10) : (m[0] ? 8'h40 : 8'h20);
    repeat (128) @(negedge clock);
    chk(timer2OvfSuppress, m[1], "suppress");
    $display("mode %0d set", m);
  endtask : setMode

  task automatic txFrame;
    logic [7:0] v;
    logic       nb;
    int         n;
    v = 8'($random(seed));
    nb = 1'($random(seed));
    bufWdata = v;
    txNinthBit = nb;
    pulse(bufWrite);
    n = 0;
    while (serialOutPin !== 1'b0 && n < 200)
    begin
      @(negedge clock);
      n++;
    end
    chk(n <= bitClks + 2, 1, "start delay");
    repeat (bitClks * 19 / 2) @(negedge clock);
    chk(txDoneFlag, 0, "done early");
    repeat (bitClks) @(negedge clock);
    chk(txDoneFlag, 1, "done late");
    repeat (bitClks) @(negedge clock);
    chk(u_node.capQ.pop_front(), {1'b1, nb, v, 1'b0}, "tx frame");
    pulse(txDoneClear);
    chk(txDoneFlag, 0, "tx clear");
  endtask : txFrame

  // Model decides acceptance, then all three results are compared
  task automatic rxFrame(input logic [7:0] v, input logic nb);
    u_node.sendFrame(v, nb);
    repeat (4) @(negedge clock);
    if (rxEnable && !mDone && (!multiprocModeBit || nb))
    begin
      mBuf = v;
      mNinth = nb;
      mDone = 1'b1;
    end
    chk(serialBuffer, mBuf, "rx byte");
    chk(rxNinthBit, mNinth, "rx ninth");
    chk(rxDoneFlag, mDone, "rx done");
  endtask : rxFrame

  // Main sequence
  initial
  begin
    seed = 80547;
    err_total = 0;
    cmp_count = 0;
    {sfrWrite, bufWrite, txNinthBit, rxEnable, multiprocModeBit, baudDoubler} = '0;
    {timerRateMode, txTimer2Select, rxTimer2Select, timer1Overflow} = '0;
    {txDoneSet, txDoneClear, rxDoneSet, rxDoneClear} = '0;
    {sfrAddr, sfrWdata, bufWdata, mBuf, d} = '0;
    {mNinth, mDone} = '0;
    timer2Reload = 16'hFFFF;
    bitClks = 8'h20;
    sys_rst = 1'b1;
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    sfrAddr = SFR_IRQ_MASK;
    #1;
    chk({serialOutPin, txDoneFlag, rxDoneFlag, rxNinthBit}, 4'h8, "reset pins");
    chk({serialBuffer, sfrRdata}, {8'h00, IRQ_MASK_RESET}, "reset regs");
    // Mask bits against every flag pattern; stray writes elsewhere ignored
    for (int i = 0; i < 16; i++)
    begin
      d = (8'($random(seed)) & 8'h6F) | {i[1], 2'b00, i[0], 4'h0};
      sfrWr(SFR_IRQ_MASK, d);
      sfrWr(8'hA9, ~d);
      #1;
      chk(sfrRdata, 8'h00, "unmapped read");
      {txDoneClear, rxDoneClear} = 2'b11;
      @(negedge clock);
      {txDoneClear, rxDoneClear} = 2'b00;
      {txDoneSet, rxDoneSet} = {i[2], i[3]};
      @(negedge clock);
      {txDoneSet, rxDoneSet} = 2'b00;
      sfrAddr = SFR_IRQ_MASK;
      #1;
      chk(sfrRdata, d & 8'hBF, "mask read");
      chk({txDoneFlag, rxDoneFlag}, {i[2], i[3]}, "soft flags");
      chk(port0IrqRequest, i[0] & i[1] & (i[2] | i[3]), "irq");
    end
    {txDoneClear, rxDoneClear} = 2'b11;
    @(negedge clock);
    {txDoneClear, rxDoneClear} = 2'b00;
    // Either timer 2 select alone stops its overflow flag
    {txTimer2Select, rxTimer2Select} = 2'b10;
    @(negedge clock);
    chk(timer2OvfSuppress, 1, "suppress tx");
    {txTimer2Select, rxTimer2Select} = 2'b01;
    @(negedge clock);
    chk(timer2OvfSuppress, 1, "suppress rx");
    {txTimer2Select, rxTimer2Select} = 2'b00;
    $display("registers done");
    rxEnable = 1'b1;
    for (int m = 0; m < 6; m++)
    begin
      setMode(3'(m));
      txFrame();
      rxFrame(8'($random(seed)), 1'($random(seed)));
      pulse(rxDoneClear);
      mDone = 1'b0;
    end
    $display("rates done");
    setMode(3'b000);
    // Every mix of clearing, filter, enable and ninth bit
    for (int i = 0; i < 16; i++)
    begin
      if (i[3])
      begin
        pulse(rxDoneClear);
        mDone = 1'b0;
      end
      multiprocModeBit = i[2];
      rxEnable = i[1];
      rxFrame(8'($random(seed)), i[0]);
    end
    $display("receive filter done");
    pulse(rxDoneClear);
    mDone = 1'b0;
    multiprocModeBit = 1'b0;
    rxEnable = 1'b1;
    u_node.glitch(4);
    chk(rxDoneFlag, 0, "glitch");
    rxFrame(8'($random(seed)), 1'b1);
    $display("glitch done");
    end_of_test();
  end

  // Watchdog well beyond the expected run of some 13000 cycles
  initial
  begin
    #(60000 * 50);
    err_total++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end
endmodule : unb_serial_bench
`default_nettype wire
